// >>> rci_ctrl.sv
// two-wire slave and control register file of the receiver
`timescale 1ns/100ps
`default_nettype none
`include "rci_defines.svh"
// Overview of operation
// - write address C2/C4/C6 chosen by straps
// - read address C3/C5/C7, same strap mapping
// - second byte of write is register index
// - third byte stored at indexed register if index is 0-6 or 9
// - further bytes go to incremented index
// - write continues until stop condition
// - acknowledge every byte received when addressed
// - read sends status first, reserved next
// - twenty fraction bits split four plus sixteen
// - predivide bit selects reference divide 1/2
// - pump select bit: 0.6mA or 1.2mA
// - second LO divide 4 or 8
// - shutdown bits power down when one
// - corner nudge shifts lowpass corner 250kHz
// - boost bit adds 4dB back-end gain
// - mixer cutback is unsigned dB count
// - test select three-bit mode code
// - trim source: factory or bus code
// - status bits agc, overcurrent, present, lock
// - reserved read byte is all zero
// - bytes shifted most significant bit first
// - fraction enable selects fractional-N mode
// - seven bits hold integer divide ratio
module rci_ctrl (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_link_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_addr_strap_hi,
    input wire logic i_addr_strap_lo,
    input wire logic i_agc_engaged,
    input wire logic i_feed_overcurrent,
    input wire logic i_feed_present,
    input wire logic i_pll_locked,
    output logic o_crystal_out_divide,
    output logic [6:0] o_divide_whole,
    output logic o_frac_enable,
    output logic [19:0] o_divide_fraction,
    output logic o_ref_predivide,
    output logic o_pump_current_select,
    output logic o_second_lo_divider_select,
    output logic o_agc_loop_off,
    output logic o_feed_protect_off,
    output logic o_front_end_off,
    output logic o_back_end_off,
    output logic o_synth_off,
    output logic [4:0] o_agc_threshold,
    output logic [1:0] o_corner_nudge,
    output logic o_backend_boost,
    output logic [3:0] o_mixer_gain_cutback,
    output logic o_crystal_buffer_off,
    output logic [2:0] o_test_select,
    output logic o_trim_source_select,
    output logic [4:0] o_trim_code
);
    import rci_pkg::*;

    // ****************************************************************
    // link reset and pin synchronisers
    // ****************************************************************
    logic link_rs1_reg;
    logic link_rstn_reg;
    logic [7:0] pins_in;
    logic [7:0] pin_s1_reg;
    logic [7:0] pin_s2_reg;
    logic [7:0] pin_s3_reg;
    logic [7:0] pin_flt_reg;
    logic [7:0] pin_flt_next;
    logic scl_prev_reg;
    logic sda_prev_reg;

    // reset enters the link domain asynchronously, leaves it on a link edge
    always_ff @(posedge i_link_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            link_rs1_reg <= 1'b0;
            link_rstn_reg <= 1'b0;
        end else begin
            link_rs1_reg <= 1'b1;
            link_rstn_reg <= link_rs1_reg;
        end
    end

    assign pins_in = {i_pll_locked, i_feed_present, i_feed_overcurrent, i_agc_engaged,
        i_addr_strap_lo, i_addr_strap_hi, i_sda, i_scl};

    // a change counts only once the last two stages agree, which also swallows bus glitches
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            always_comb begin
                pin_flt_next[gi] = (pin_s2_reg[gi] == pin_s3_reg[gi]) ? pin_s3_reg[gi] : pin_flt_reg[gi];
            end
            always_ff @(posedge i_link_clk or negedge link_rstn_reg) begin
                if (!link_rstn_reg) begin
                    pin_s1_reg[gi] <= 1'b1;
                    pin_s2_reg[gi] <= 1'b1;
                    pin_s3_reg[gi] <= 1'b1;
                    pin_flt_reg[gi] <= 1'b1;
                end else begin
                    pin_s1_reg[gi] <= pins_in[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                    pin_s3_reg[gi] <= pin_s2_reg[gi];
                    pin_flt_reg[gi] <= pin_flt_next[gi];
                end
            end
        end
    endgenerate

    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [1:0] strap;
    logic addr_match;
    rci_byte_type status_byte;

    assign scl_f = pin_flt_reg[0];
    assign sda_f = pin_flt_reg[1];
    assign strap = {pin_flt_reg[2], pin_flt_reg[3]};
    assign scl_rise = scl_f & ~scl_prev_reg;
    assign scl_fall = ~scl_f & scl_prev_reg;
    assign start_det = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
    assign stop_det = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;
    assign status_byte = {4'h0, pin_flt_reg[4], pin_flt_reg[5], pin_flt_reg[6], pin_flt_reg[7]};

    // ****************************************************************
    // link state machine
    // ****************************************************************
    rci_state_type state_reg;
    rci_state_type state_next;
    rci_kind_type kind_reg;
    rci_kind_type kind_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    rci_byte_type shift_reg;
    rci_byte_type shift_next;
    rci_byte_type tx_reg;
    rci_byte_type tx_next;
    rci_byte_type idx_reg;
    rci_byte_type idx_next;
    rci_byte_type wr_idx_reg;
    rci_byte_type wr_idx_next;
    rci_byte_type wr_data_reg;
    rci_byte_type wr_data_next;
    logic wr_tgl_reg;
    logic wr_tgl_next;
    logic reading_reg;
    logic reading_next;
    logic mack_ok_reg;
    logic mack_ok_next;
    logic sda_oe_reg;
    logic sda_oe_next;

    // a zero strap pair selects no address at all, so the slave stays deaf
    assign addr_match = (shift_reg[7:3] == `RCI_ADDR_BASE) && (shift_reg[2:1] == strap)
        && (strap != 2'h0);

    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        idx_next = idx_reg;
        wr_idx_next = wr_idx_reg;
        wr_data_next = wr_data_reg;
        wr_tgl_next = wr_tgl_reg;
        reading_next = reading_reg;
        mack_ok_next = mack_ok_reg;
        sda_oe_next = sda_oe_reg;
        if (stop_det) begin
            state_next = RCI_ST_IDLE;
            sda_oe_next = 1'b0;
        end else if (start_det) begin
            state_next = RCI_ST_RECV;
            kind_next = RCI_KIND_ADDR;
            cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end else begin
            unique case (state_reg)
                RCI_ST_IDLE: begin
                    sda_oe_next = 1'b0;
                end
                RCI_ST_RECV: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_f};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == 4'h8) begin
                        cnt_next = 4'h0;
                        unique case (kind_reg)
                            RCI_KIND_ADDR: begin
                                if (addr_match) begin
                                    reading_next = shift_reg[0];
                                    kind_next = RCI_KIND_INDEX;
                                    state_next = RCI_ST_ACK;
                                    sda_oe_next = 1'b1;
                                end else begin
                                    state_next = RCI_ST_IDLE;
                                end
                            end
                            RCI_KIND_INDEX: begin
                                idx_next = shift_reg;
                                kind_next = RCI_KIND_DATA;
                                state_next = RCI_ST_ACK;
                                sda_oe_next = 1'b1;
                            end
                            RCI_KIND_DATA: begin
                                wr_idx_next = idx_reg;
                                wr_data_next = shift_reg;
                                wr_tgl_next = ~wr_tgl_reg;
                                idx_next = idx_reg + 8'h01;
                                state_next = RCI_ST_ACK;
                                sda_oe_next = 1'b1;
                            end
                            default: begin
                                state_next = RCI_ST_IDLE;
                            end
                        endcase
                    end
                end
                RCI_ST_ACK: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        if (reading_reg) begin
                            state_next = RCI_ST_SEND;
                            tx_next = status_byte;
                            sda_oe_next = ~status_byte[7];
                        end else begin
                            state_next = RCI_ST_RECV;
                            sda_oe_next = 1'b0;
                        end
                    end
                end
                RCI_ST_SEND: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == 4'h8) begin
                            state_next = RCI_ST_MACK;
                            cnt_next = 4'h0;
                            sda_oe_next = 1'b0;
                        end else begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            sda_oe_next = ~tx_reg[6];
                        end
                    end
                end
                RCI_ST_MACK: begin
                    if (scl_rise) begin
                        mack_ok_next = ~sda_f;
                    end else if (scl_fall) begin
                        if (mack_ok_reg) begin
                            // everything after the status byte reads as the reserved byte
                            state_next = RCI_ST_SEND;
                            tx_next = `RCI_RD_RESERVED;
                            sda_oe_next = ~tx_next[7];
                        end else begin
                            state_next = RCI_ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = RCI_ST_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge link_rstn_reg) begin
        if (!link_rstn_reg) begin
            state_reg <= RCI_ST_IDLE;
            kind_reg <= RCI_KIND_ADDR;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            idx_reg <= 8'h00;
            wr_idx_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            wr_tgl_reg <= 1'b0;
            reading_reg <= 1'b0;
            mack_ok_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            o_sda_out <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            idx_reg <= idx_next;
            wr_idx_reg <= wr_idx_next;
            wr_data_reg <= wr_data_next;
            wr_tgl_reg <= wr_tgl_next;
            reading_reg <= reading_next;
            mack_ok_reg <= mack_ok_next;
            sda_oe_reg <= sda_oe_next;
            o_sda_out <= 1'b0;
            scl_prev_reg <= scl_f;
            sda_prev_reg <= sda_f;
        end
    end
    assign o_sda_oe = sda_oe_reg;

    // ****************************************************************
    // write crossing and register file
    // ****************************************************************
    // index and data hold still for a whole byte time after the toggle, so the core reads them directly
    logic tg_s1_reg;
    logic tg_s2_reg;
    logic tg_s3_reg;
    logic wr_evt;
    logic wr_ok;
    rci_byte_type regs_reg [10];
    rci_byte_type regs_next [10];

    assign wr_evt = tg_s2_reg ^ tg_s3_reg;
    assign wr_ok = (wr_idx_reg < `RCI_OFS_SPARE7) || (wr_idx_reg == `RCI_OFS_TRIM);

    always_comb begin
        for (int i = 0; i < 10; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (wr_evt && wr_ok) begin
            if (wr_idx_reg == `RCI_OFS_TRIM) begin
                regs_next[9] = wr_data_reg & `RCI_TRIM_MASK;
            end else begin
                regs_next[wr_idx_reg[2:0]] = wr_data_reg;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tg_s1_reg <= 1'b0;
            tg_s2_reg <= 1'b0;
            tg_s3_reg <= 1'b0;
            for (int i = 0; i < 10; i++) begin
                regs_reg[i] <= RCI_RESET_VALS[i];
            end
        end else begin
            tg_s1_reg <= wr_tgl_reg;
            tg_s2_reg <= tg_s1_reg;
            tg_s3_reg <= tg_s2_reg;
            for (int i = 0; i < 10; i++) begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    // ****************************************************************
    // control fields
    // ****************************************************************
    assign o_crystal_out_divide = regs_reg[0][`RCI_XO_DIV_BIT];
    assign o_divide_whole = regs_reg[0][6:0];
    assign o_frac_enable = regs_reg[1][`RCI_FRAC_EN_BIT];
    assign o_divide_fraction = {regs_reg[1][3:0], regs_reg[2], regs_reg[3]};
    assign o_ref_predivide = regs_reg[4][`RCI_REF_BIT];
    assign o_pump_current_select = regs_reg[4][`RCI_CHP_BIT];
    assign o_second_lo_divider_select = regs_reg[4][`RCI_LODIV_BIT];
    assign o_agc_loop_off = regs_reg[4][`RCI_AGC_OFF_BIT];
    assign o_feed_protect_off = regs_reg[4][`RCI_FEED_OFF_BIT];
    assign o_front_end_off = regs_reg[4][`RCI_FE_OFF_BIT];
    assign o_back_end_off = regs_reg[4][`RCI_BE_OFF_BIT];
    assign o_synth_off = regs_reg[4][`RCI_SYN_OFF_BIT];
    assign o_agc_threshold = regs_reg[5][7:3];
    assign o_corner_nudge = regs_reg[5][2:1];
    assign o_backend_boost = regs_reg[5][`RCI_BOOST_BIT];
    assign o_mixer_gain_cutback = regs_reg[6][7:4];
    assign o_crystal_buffer_off = regs_reg[6][`RCI_XBUF_OFF_BIT];
    assign o_test_select = regs_reg[6][2:0];
    assign o_trim_source_select = regs_reg[9][`RCI_TRIM_SRC_BIT];
    assign o_trim_code = regs_reg[9][4:0];

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_ack_low;
        @(posedge i_link_clk) disable iff (!link_rstn_reg)
        (state_reg == RCI_ST_ACK) |-> sda_oe_reg;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack not driven");

    property p_foreign_ignored;
        @(posedge i_link_clk) disable iff (!link_rstn_reg)
        (state_reg == RCI_ST_RECV && kind_reg == RCI_KIND_ADDR && scl_fall && cnt_reg == 4'h8 && !addr_match
            && !stop_det && !start_det) |=> (state_reg == RCI_ST_IDLE) && !sda_oe_reg;
    endproperty
    a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign address answered");

    property p_addr_taken;
        @(posedge i_link_clk) disable iff (!link_rstn_reg)
        (state_reg == RCI_ST_RECV && kind_reg == RCI_KIND_ADDR && scl_fall && cnt_reg == 4'h8 && addr_match
            && !stop_det && !start_det) |=> (state_reg == RCI_ST_ACK) && (reading_reg == $past(shift_reg[0]));
    endproperty
    a_addr_taken: assert property (p_addr_taken) else $error("own address not taken");

    property p_status_first;
        @(posedge i_link_clk) disable iff (!link_rstn_reg)
        (state_reg == RCI_ST_ACK && reading_reg && scl_fall && !stop_det && !start_det)
            |=> (state_reg == RCI_ST_SEND) && (tx_reg[7:4] == 4'h0) && (tx_reg[3:0] == $past(status_byte[3:0]));
    endproperty
    a_status_first: assert property (p_status_first) else $error("status byte not sent first");

    property p_reserved_zero;
        @(posedge i_link_clk) disable iff (!link_rstn_reg)
        (state_reg == RCI_ST_MACK && scl_fall && mack_ok_reg && !stop_det && !start_det) |=> tx_reg == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved byte not zero");

    property p_index_step;
        @(posedge i_link_clk) disable iff (!link_rstn_reg)
        (wr_tgl_reg != $past(wr_tgl_reg)) |-> (idx_reg == wr_idx_reg + 8'h01);
    endproperty
    a_index_step: assert property (p_index_step) else $error("index did not advance");

    property p_stop_ends;
        @(posedge i_link_clk) disable iff (!link_rstn_reg)
        stop_det |=> (state_reg == RCI_ST_IDLE) && !sda_oe_reg ##1 (state_reg == RCI_ST_IDLE);
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop did not end transfer");

    property p_reg_store;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (wr_evt && wr_idx_reg == `RCI_OFS_CONTROL) |=> (regs_reg[4] == $past(wr_data_reg)) && $stable(regs_reg[5]);
    endproperty
    a_reg_store: assert property (p_reg_store) else $error("write not stored");

    property p_spare_zero;
        @(posedge i_core_clk) disable iff (!i_resetn)
        wr_evt |=> (regs_reg[7] == 8'h00) && (regs_reg[8] == 8'h00) && (regs_reg[9][7:6] == 2'h0);
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare bits written");

    c_write: cover property (@(posedge i_core_clk) disable iff (!i_resetn) wr_evt && wr_ok);
    c_read: cover property (@(posedge i_link_clk) disable iff (!link_rstn_reg) state_reg == RCI_ST_MACK ##1
        state_reg == RCI_ST_SEND);
    c_foreign: cover property (@(posedge i_link_clk) disable iff (!link_rstn_reg)
        state_reg == RCI_ST_RECV && kind_reg == RCI_KIND_ADDR && scl_fall && cnt_reg == 4'h8 && !addr_match);
endmodule : rci_ctrl
`default_nettype wire

// >>> rci_defines.svh
// register offsets, field positions, reset values and bus codes of the receiver control interface
`ifndef RCI_DEFINES_SVH
`define RCI_DEFINES_SVH
`define RCI_OFS_INT 8'h00
`define RCI_OFS_FRAC_HI 8'h01
`define RCI_OFS_FRAC_MID 8'h02
`define RCI_OFS_FRAC_LO 8'h03
`define RCI_OFS_CONTROL 8'h04
`define RCI_OFS_GAIN 8'h05
`define RCI_OFS_MIXTEST 8'h06
`define RCI_OFS_SPARE7 8'h07
`define RCI_OFS_SPARE8 8'h08
`define RCI_OFS_TRIM 8'h09
`define RCI_OFS_SPARE10 8'h10
`define RCI_RST_INT 8'h56
`define RCI_RST_FRAC_HI 8'h1e
`define RCI_RST_FRAC_MID 8'h90
`define RCI_RST_FRAC_LO 8'h69
`define RCI_RST_CONTROL 8'h60
`define RCI_RST_GAIN 8'h04
`define RCI_RST_MIXTEST 8'h00
`define RCI_RST_SPARE 8'h00
`define RCI_RST_TRIM 8'h00
`define RCI_TRIM_MASK 8'h3f
`define RCI_RD_RESERVED 8'h00
`define RCI_ADDR_BASE 5'h18
`define RCI_XO_DIV_BIT 7
`define RCI_FRAC_EN_BIT 4
`define RCI_REF_BIT 7
`define RCI_CHP_BIT 6
`define RCI_LODIV_BIT 5
`define RCI_AGC_OFF_BIT 4
`define RCI_FEED_OFF_BIT 3
`define RCI_FE_OFF_BIT 2
`define RCI_BE_OFF_BIT 1
`define RCI_SYN_OFF_BIT 0
`define RCI_BOOST_BIT 0
`define RCI_XBUF_OFF_BIT 3
`define RCI_TRIM_SRC_BIT 5
`endif

// >>> rci_pkg.sv
// types shared by the receiver control interface
package rci_pkg;
    `include "rci_defines.svh"
    typedef enum logic [2:0] {
        RCI_ST_IDLE = 3'h0,
        RCI_ST_RECV = 3'h1,
        RCI_ST_ACK = 3'h3,
        RCI_ST_SEND = 3'h2,
        RCI_ST_MACK = 3'h6
    } rci_state_type;
    typedef enum logic [1:0] {
        RCI_KIND_ADDR = 2'h0,
        RCI_KIND_INDEX = 2'h1,
        RCI_KIND_DATA = 2'h3
    } rci_kind_type;
    typedef logic [7:0] rci_byte_type;
    localparam rci_byte_type RCI_RESET_VALS [10] = '{`RCI_RST_INT, `RCI_RST_FRAC_HI, `RCI_RST_FRAC_MID,
        `RCI_RST_FRAC_LO, `RCI_RST_CONTROL, `RCI_RST_GAIN, `RCI_RST_MIXTEST, `RCI_RST_SPARE, `RCI_RST_SPARE,
        `RCI_RST_TRIM};
endpackage : rci_pkg

// >>> rci_master.sv
// two-wire bus master model standing in for the baseband controller
`timescale 1ns/100ps
`default_nettype none
module rci_master (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    localparam int HALF = 300;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // data moves mid low phase so setup and hold both get half a phase
    task automatic bit_io(input logic b, output logic r);
        #(HALF / 2) o_sda_low = ~b;
        #(HALF / 2) o_scl = 1'b1;
        #(HALF / 2) r = i_sda;
        #(HALF / 2) o_scl = 1'b0;
    endtask : bit_io
    task automatic start();
        o_sda_low = 1'b0;
        #HALF o_sda_low = 1'b1;
        #HALF o_scl = 1'b0;
    endtask : start
    // ninth bit: 1 releases the line, 0 gives the master acknowledge
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(last, ack);
    endtask : xfer
    task automatic stop();
        #(HALF / 2) o_sda_low = 1'b1;
        #(HALF / 2) o_scl = 1'b1;
        #HALF o_sda_low = 1'b0;
        #HALF;
    endtask : stop
endmodule : rci_master
`default_nettype wire

// >>> rci_ctrl_tb.sv
// self-checking bench of the receiver control interface
`timescale 1ns/100ps
`default_nettype none
module rci_ctrl_tb;
    import rci_pkg::*;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] strap = 2'h1;
    logic [3:0] stat = 4'h0;
    logic scl;
    logic m_low;
    logic sda_oe;
    logic sda_out;
    logic [7:0] rd;
    logic ak;
    wire logic sda_line;
    wire logic [63:0] img;
    int failures = 0;
    int n_checks = 0;
    always #12.5 clk = ~clk;
    initial begin
        #3.7;
        forever #6 lclk = ~lclk;
    end
    // open drain with pull-up: low when either party pulls, the slave pulling with its output value
    assign sda_line = ~(m_low | (sda_oe & ~sda_out));
    assign img[55:53] = 3'h0;
    assign img[7:6] = 2'h0;
    rci_master rci_master_inst (.i_sda(sda_line), .o_scl(scl), .o_sda_low(m_low));
    rci_ctrl rci_ctrl_inst (.i_core_clk(clk), .i_resetn(rstn), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda_line),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_strap_hi(strap[1]), .i_addr_strap_lo(strap[0]),
        .i_agc_engaged(stat[3]), .i_feed_overcurrent(stat[2]), .i_feed_present(stat[1]), .i_pll_locked(stat[0]),
        .o_crystal_out_divide(img[63]), .o_divide_whole(img[62:56]), .o_frac_enable(img[52]),
        .o_divide_fraction(img[51:32]), .o_ref_predivide(img[31]), .o_pump_current_select(img[30]),
        .o_second_lo_divider_select(img[29]), .o_agc_loop_off(img[28]), .o_feed_protect_off(img[27]),
        .o_front_end_off(img[26]), .o_back_end_off(img[25]), .o_synth_off(img[24]), .o_agc_threshold(img[23:19]),
        .o_corner_nudge(img[18:17]), .o_backend_boost(img[16]), .o_mixer_gain_cutback(img[15:12]),
        .o_crystal_buffer_off(img[11]), .o_test_select(img[10:8]), .o_trim_source_select(img[5]),
        .o_trim_code(img[4:0]));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic put(input logic [7:0] d);
        rci_master_inst.xfer(d, 1'b1, rd, ak);
        chk({63'h0, ak}, 64'h0);
    endtask : put
    task automatic pins(input logic [1:0] s, input logic [3:0] st);
        @(posedge clk);
        #1 strap = s;
        stat = st;
        #500;
    endtask : pins
    task automatic t_burst();
        logic [7:0] v [10] = '{8'ha5, 8'h17, 8'h21, 8'h02, 8'h96, 8'h6b, 8'hd2, 8'h3c, 8'hc3, 8'he0};
        rci_master_inst.start();
        put(8'hc2);
        put(8'h00);
        foreach (v[i]) put(v[i]);
        rci_master_inst.stop();
        #500;
        chk(img, 64'ha5172102_966bd220);
    endtask : t_burst
    // foreign address, then strap 00 which answers no address: slave must stay silent throughout
    task automatic t_foreign();
        logic [7:0] v [3] = '{8'hc4, 8'h00, 8'h00};
        for (int k = 0; k < 2; k++) begin
            pins(2'(1 - k), 4'h0);
            rci_master_inst.start();
            foreach (v[i]) begin
                rci_master_inst.xfer(v[i] ^ 8'(k * 6), 1'b1, rd, ak);
                chk({63'h0, ak}, 64'h1);
            end
            rci_master_inst.stop();
            #500;
            chk(img, 64'ha5172102_966bd220);
        end
    endtask : t_foreign
    task automatic t_codes();
        logic [1:0] s;
        for (int i = 0; i < 8; i++) begin
            s = 2'(i % 3 + 1);
            pins(s, 4'h0);
            rci_master_inst.start();
            put(8'hc0 + {5'h0, s, 1'b0});
            put(8'h06);
            put(8'(i * 8'h11));
            rci_master_inst.stop();
            #500;
            chk({56'h0, img[15:8]}, 64'(i * 8'h11));
        end
    endtask : t_codes
    task automatic t_read();
        for (int s = 1; s < 4; s++) begin
            pins(2'(s), 4'(5 * s));
            rci_master_inst.start();
            put(8'hc1 + 8'(2 * s));
            rci_master_inst.xfer(8'hff, 1'b0, rd, ak);
            chk({56'h0, rd}, 64'(5 * s));
            rci_master_inst.xfer(8'hff, 1'b1, rd, ak);
            chk({56'h0, rd}, 64'h0);
            rci_master_inst.stop();
        end
    endtask : t_read
    task automatic summarize();
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #2000000;
        failures++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (10) @(posedge clk);
        chk(img, 64'h561e9069_60040000);
        t_burst();
        t_foreign();
        t_codes();
        t_read();
        summarize();
    end
endmodule : rci_ctrl_tb
`default_nettype wire
